/* verilog/mpba_pkg.sv */
// ==========================================================
// Shared constants for the multiprocessor bus arbitration ends
package mpba_pkg;

    // ==========================================================
    // Bus request lines and processor identity
    localparam int          MPBA_NUM_LINES = 6;     // Request lines
    localparam int          MPBA_ID_WIDTH  = 3;     // Id pin count
    localparam logic [2:0]  MPBA_LONE_ID   = 3'h0;  // Lone processor
    localparam logic [2:0]  MPBA_MAX_ID    = 3'h6;  // Highest line id
    localparam logic [2:0]  MPBA_NO_OWNER  = 3'h0;  // Nobody owns bus

    // ==========================================================
    // Pin levels and reset values (pins active low)
    localparam logic        MPBA_ASSERT    = 1'b0;  // Active level
    localparam logic        MPBA_IDLE_LVL  = 1'b1;  // Inactive level
    localparam logic [5:0]  MPBA_LINES_OFF = 6'h3F; // All lines high

    // ==========================================================
    // Timing: host grant floats this many cycles before driven
    localparam int          MPBA_HOST_FLOAT_CYCLES = 1;
    localparam logic [1:0]  MPBA_FLOAT_CNT = 2'h1;

    // ==========================================================
    // Node state machine
    typedef enum logic [2:0] {
        MPBA_ST_IDLE       = 3'b000,  // Not requesting
        MPBA_ST_REQUEST    = 3'b001,  // Own line driven low
        MPBA_ST_OWNER      = 3'b010,  // Holding the shared bus
        MPBA_ST_HOST_FLOAT = 3'b011,  // Bus released, grant floats
        MPBA_ST_HOST_GRANT = 3'b100   // Host grant driven low
    } mpba_state_type;

endpackage

/* verilog/mpba_if.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Shared bus pins; open-drain lines resolved with pull-ups here
interface mpba_if;
    import mpba_pkg::*;

    // Request lines: node drive, system drive, resolved level
    logic [5:0] br_node_out;      // Node drive value
    logic [5:0] br_node_oe;       // Node drive enable
    logic [5:0] br_sys_out;       // Peer drive value
    logic [5:0] br_sys_oe;        // Peer drive enable
    logic [5:0] br_n;             // Resolved request lines
    // Host side
    logic       hbr_n;            // Host bus request
    logic       cs_n;             // Host chip select
    logic       hbg_out;          // Host grant drive value
    logic       hbg_oe;           // Host grant drive enable
    logic       hbg_n;            // Resolved host grant
    logic       ack_out;          // Host acknowledge drive value
    logic       ack_oe;           // Host acknowledge enable
    logic       host_access_ack;  // Resolved acknowledge
    // DMA
    logic       dma_request_a_n;  // Channel 11 request
    logic       dma_request_b_n;  // Channel 12 request
    logic       dga_out;          // Grant A drive value
    logic       dga_oe;           // Grant A drive enable
    logic       dgb_out;          // Grant B drive value
    logic       dgb_oe;           // Grant B drive enable
    logic       dma_grant_a_n;    // Resolved grant A
    logic       dma_grant_b_n;    // Resolved grant B
    // Configuration and status
    logic       current_owner_flag;       // Bus master indicator
    logic       rotating_priority_select; // Rotating when high
    logic [2:0] processor_id_pins;        // Hardwired id

    // Wire resolution, unpulled lines read high
    genvar gi;
    for (gi = 0; gi < MPBA_NUM_LINES; gi++) begin : g_line
        assign br_n[gi] = br_node_oe[gi] ? br_node_out[gi] :
                          br_sys_oe[gi]  ? br_sys_out[gi]  : MPBA_IDLE_LVL;
    end
    assign hbg_n           = hbg_oe ? hbg_out : MPBA_IDLE_LVL;
    assign host_access_ack = ack_oe ? ack_out : MPBA_IDLE_LVL;
    assign dma_grant_a_n   = dga_oe ? dga_out : MPBA_IDLE_LVL;
    assign dma_grant_b_n   = dgb_oe ? dgb_out : MPBA_IDLE_LVL;

    modport node (
        output br_node_out, br_node_oe, hbg_out, hbg_oe, ack_out, ack_oe,
        output dga_out, dga_oe, dgb_out, dgb_oe, current_owner_flag,
        input  br_n, hbr_n, cs_n, dma_request_a_n, dma_request_b_n,
        input  rotating_priority_select, processor_id_pins, hbg_n
    );
    modport sys (
        output br_sys_out, br_sys_oe, hbr_n, cs_n,
        output dma_request_a_n, dma_request_b_n,
        output rotating_priority_select, processor_id_pins,
        input  br_n, hbg_n, host_access_ack, dma_grant_a_n,
        input  dma_grant_b_n, current_owner_flag
    );
endinterface
`default_nettype wire

/* verilog/mpba_node.sv */
`timescale 1ns/1ns
`default_nettype none
module mpba_node
    import mpba_pkg::*;
#(
    parameter int NUM_LINES = MPBA_NUM_LINES  // Request line count
) (
    input  wire logic clock,            // Input clock, 10 MHz
    input  wire logic resetn,           // Sync reset, active low
    mpba_if.node      pins,             // Shared bus pins
    input  wire logic bus_want,         // Core wants the bus
    input  wire logic dma_allow,        // Core accepts DMA cycles
    input  wire logic io_regs_ready,    // Register access can end
    output logic      bus_owned,        // Node owns the bus
    output logic      bus_release,      // Address/data/strobes floated
    output logic      dma_start_a,      // Channel 11 transfer now
    output logic      dma_start_b,      // Channel 12 transfer now
    output logic      host_owns_bus     // Host granted
);
    // ==========================================================
    // Elaboration check: arbitration logic serves six lines only
    if (NUM_LINES != MPBA_NUM_LINES) begin : g_bad_lines
        $error("mpba_node: NUM_LINES must be 6");
    end
    // ==========================================================
    // Declarations
    mpba_state_type state;            // Node state
    mpba_state_type next_state;       // Next node state
    logic [2:0]     master_id;        // Current owner, shared view
    logic [2:0]     last_master;      // Rotation origin
    logic [2:0]     next_master;      // Next owner view
    logic [2:0]     winner;           // Arbitration result
    logic [5:0]     req;              // Active-high requests
    logic [2:0]     my_id;            // Id captured while in reset
    logic           lone;             // Single processor system
    logic           dga_pend;         // Grant A issued last cycle
    logic           dgb_pend;         // Grant B issued last cycle
    logic           grant_a;          // Issue grant A
    logic           grant_b;          // Issue grant B
    logic           i_own;            // Shared view says we own
    // ==========================================================
    // Functions
    // Pick first requester, starting after origin when rotating
    function automatic logic [2:0] pick(input logic [5:0] r,
                                        input logic [2:0] origin,
                                        input logic       rot);
        logic [2:0] result;
        logic [2:0] idx;
        result = MPBA_NO_OWNER;
        idx    = 3'h0;
        for (int i = MPBA_NUM_LINES - 1; i >= 0; i--) begin
            idx = rot ? 3'((int'(origin) + i) % MPBA_NUM_LINES) : 3'(i);
            if (r[idx]) begin
                result = idx + 3'h1;
            end
        end
        return result;
    endfunction
    // Line mask for an id; zero id maps to no line
    function automatic logic [5:0] line_mask(input logic [2:0] id);
        logic [5:0] m;
        m = 6'h00;
        if (id != MPBA_LONE_ID && id <= MPBA_MAX_ID) begin
            m[id - 3'h1] = 1'b1;
        end
        return m;
    endfunction
    // ==========================================================
    // Id capture; pins are assumed static outside reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            my_id <= pins.processor_id_pins;
        end
    end

    assign lone = (my_id == MPBA_LONE_ID);
    // ==========================================================
    // Shared arbitration view, identical in every node
    assign req    = ~pins.br_n;
    // Rotation origin is last owner's line; fixed starts at line 1
    assign winner = pick(req, last_master,
                         pins.rotating_priority_select);

    always_comb begin
        next_master = master_id;
        // Host request freezes handover so no processor can win
        if (pins.hbr_n != MPBA_ASSERT && (master_id == MPBA_NO_OWNER ||
                                          !req[master_id - 3'h1])) begin
            next_master = winner;
        end
    end

    // Owner register; origin kept so rotation survives idle bus
    always_ff @(posedge clock) begin
        if (!resetn) begin
            master_id   <= MPBA_NO_OWNER;
            last_master <= 3'h0;
        end else begin
            master_id <= next_master;
            if (next_master != MPBA_NO_OWNER) begin
                last_master <= next_master;
            end
        end
    end

    assign i_own = lone || (master_id == my_id);
    // ==========================================================
    // Node state machine
    always_comb begin
        next_state = state;
        case (state)
            MPBA_ST_IDLE: begin
                if (bus_want && !lone) begin
                    next_state = MPBA_ST_REQUEST;
                end else if (lone && pins.hbr_n == MPBA_ASSERT) begin
                    next_state = MPBA_ST_HOST_FLOAT;
                end else if (lone && bus_want) begin
                    next_state = MPBA_ST_OWNER;
                end
            end
            MPBA_ST_REQUEST: begin
                if (i_own) begin
                    next_state = MPBA_ST_OWNER;
                end
            end
            MPBA_ST_OWNER: begin
                // Host wins over our own tenure
                if (pins.hbr_n == MPBA_ASSERT) begin
                    next_state = MPBA_ST_HOST_FLOAT;
                end else if (!bus_want) begin
                    next_state = MPBA_ST_IDLE;
                end
            end
            MPBA_ST_HOST_FLOAT: begin
                next_state = MPBA_ST_HOST_GRANT;
            end
            MPBA_ST_HOST_GRANT: begin
                if (pins.hbr_n != MPBA_ASSERT) begin
                    next_state = bus_want ? MPBA_ST_OWNER : MPBA_ST_IDLE;
                end
            end
            default: begin
                next_state = MPBA_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= MPBA_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end
    // ==========================================================
    // Own request line: low while requesting or holding the bus
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pins.br_node_out <= MPBA_LINES_OFF;
            pins.br_node_oe  <= 6'h00;
        end else begin
            pins.br_node_oe  <= line_mask(my_id);
            if (next_state != MPBA_ST_IDLE) begin
                pins.br_node_out <= ~line_mask(my_id);
            end else begin
                pins.br_node_out <= MPBA_LINES_OFF;
            end
        end
    end
    // ==========================================================
    // Host grant: floats in the release cycle, then driven low
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pins.hbg_out <= MPBA_IDLE_LVL;
            pins.hbg_oe  <= 1'b0;
        end else begin
            pins.hbg_out <= (next_state == MPBA_ST_HOST_GRANT) ?
                            MPBA_ASSERT : MPBA_IDLE_LVL;
            // Only the owner side drives; float during release
            pins.hbg_oe  <= (next_state == MPBA_ST_HOST_GRANT) ||
                            (next_state == MPBA_ST_OWNER);
        end
    end
    // ==========================================================
    // Master indicator and user status flags
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pins.current_owner_flag <= 1'b0;
            bus_owned     <= 1'b0;
            bus_release   <= 1'b1;
            host_owns_bus <= 1'b0;
        end else begin
            // Lone id always master; others only while owning
            pins.current_owner_flag <= lone ||
                (next_state == MPBA_ST_OWNER);
            bus_owned     <= (next_state == MPBA_ST_OWNER);
            bus_release   <= (next_state != MPBA_ST_OWNER);
            host_owns_bus <= (next_state == MPBA_ST_HOST_GRANT);
        end
    end
    // ==========================================================
    // DMA grants; A wins a tie, one grant then one gap cycle
    // No grant in the cycle the bus is given up, pins float next
    assign grant_a = (state == MPBA_ST_OWNER) && (next_state == state)
                     && dma_allow && !dga_pend && !dgb_pend
                     && pins.dma_request_a_n == MPBA_ASSERT;
    assign grant_b = (state == MPBA_ST_OWNER) && (next_state == state)
                     && dma_allow && !dga_pend && !dgb_pend && !grant_a
                     && pins.dma_request_b_n == MPBA_ASSERT;

    // Grant pins driven only while owner, floated otherwise
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pins.dga_out <= MPBA_IDLE_LVL;
            pins.dgb_out <= MPBA_IDLE_LVL;
            pins.dga_oe  <= 1'b0;
            pins.dgb_oe  <= 1'b0;
            dga_pend     <= 1'b0;
            dgb_pend     <= 1'b0;
        end else begin
            // Same edge as the master flag, so no stale drive
            pins.dga_oe  <= (next_state == MPBA_ST_OWNER);
            pins.dgb_oe  <= (next_state == MPBA_ST_OWNER);
            pins.dga_out <= grant_a ? MPBA_ASSERT : MPBA_IDLE_LVL;
            pins.dgb_out <= grant_b ? MPBA_ASSERT : MPBA_IDLE_LVL;
            dga_pend     <= grant_a;
            dgb_pend     <= grant_b;
        end
    end

    // Transfer begins the cycle after the grant cycle
    always_ff @(posedge clock) begin
        if (!resetn) begin
            dma_start_a <= 1'b0;
            dma_start_b <= 1'b0;
        end else begin
            dma_start_a <= dga_pend;
            dma_start_b <= dgb_pend;
        end
    end
    // ==========================================================
    // Host acknowledge: open drain, pulls low to stretch access
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pins.ack_out <= MPBA_ASSERT;
            pins.ack_oe  <= 1'b0;
        end else begin
            pins.ack_out <= MPBA_ASSERT;
            pins.ack_oe  <= pins.cs_n == MPBA_ASSERT &&
                            pins.hbr_n == MPBA_ASSERT &&
                            !io_regs_ready;
        end
    end
endmodule
`default_nettype wire

/* verilog/mpba_system.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Far end: peer processors, host and DMA device as pin drivers
module mpba_system
    import mpba_pkg::*;
#(
    parameter int NUM_LINES = MPBA_NUM_LINES  // Request line count
) (
    input  wire logic       clock,         // Input clock
    input  wire logic       resetn,        // Sync reset, active low
    mpba_if.sys             pins,          // Shared bus pins
    input  wire logic [2:0] node_id,       // Id strapped on the node
    input  wire logic [5:0] peer_want,     // Peers requesting per line
    input  wire logic [5:0] peer_present,  // Lines with a peer behind
    input  wire logic       host_want,     // Host wants the bus
    input  wire logic       host_select,   // Host selects the node
    input  wire logic       dma_want_a,    // Device wants channel 11
    input  wire logic       dma_want_b,    // Device wants channel 12
    input  wire logic       rotate,        // Rotating priority wanted
    output logic            host_granted,  // Host grant seen low
    output logic            host_wait,     // Acknowledge seen low
    output logic            dma_granted_a, // Grant A seen low
    output logic            dma_granted_b, // Grant B seen low
    output logic            node_master    // Node master indicator
);

    // ==========================================================
    // Elaboration check: six request lines only
    if (NUM_LINES != MPBA_NUM_LINES) begin : g_bad_lines
        $error("mpba_system: NUM_LINES must be 6");
    end

    logic [5:0] own_line;  // Line reserved for the node

    // Node line is never driven or pulled from this side
    always_comb begin
        own_line = 6'h00;
        if (node_id != MPBA_LONE_ID && node_id <= MPBA_MAX_ID) begin
            own_line[node_id - 3'h1] = 1'b1;
        end
    end

    // Id strap held constant; changes belong under reset only
    assign pins.processor_id_pins = node_id;

    // ==========================================================
    // Pin drivers, registered so every input changes on one edge
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pins.br_sys_out               <= MPBA_LINES_OFF;
            pins.br_sys_oe                <= 6'h00;
            pins.hbr_n                    <= MPBA_IDLE_LVL;
            pins.cs_n                     <= MPBA_IDLE_LVL;
            pins.dma_request_a_n          <= MPBA_IDLE_LVL;
            pins.dma_request_b_n          <= MPBA_IDLE_LVL;
            pins.rotating_priority_select <= 1'b0;
        end else begin
            // Absent peers float; interface pull-up keeps them high
            pins.br_sys_oe  <= peer_present & ~own_line;
            pins.br_sys_out <= ~peer_want;
            pins.hbr_n      <= ~host_want;
            pins.cs_n       <= ~host_select;
            pins.dma_request_a_n <= ~dma_want_a;
            pins.dma_request_b_n <= ~dma_want_b;
            // One register feeds every processor in the same cycle
            pins.rotating_priority_select <= rotate;
        end
    end

    // ==========================================================
    // Observed pin states back to the user side
    always_ff @(posedge clock) begin
        if (!resetn) begin
            host_granted  <= 1'b0;
            host_wait     <= 1'b0;
            dma_granted_a <= 1'b0;
            dma_granted_b <= 1'b0;
            node_master   <= 1'b0;
        end else begin
            host_granted  <= pins.hbg_n == MPBA_ASSERT;
            host_wait     <= pins.host_access_ack == MPBA_ASSERT;
            dma_granted_a <= pins.dma_grant_a_n == MPBA_ASSERT;
            dma_granted_b <= pins.dma_grant_b_n == MPBA_ASSERT;
            node_master   <= pins.current_owner_flag;
        end
    end

endmodule
`default_nettype wire

/* test/mpba_checker_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Pin protocol checks beside the shared bus
module mpba_checker
    import mpba_pkg::*;
(
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic [5:0] br_n,
    input wire logic [5:0] br_node_oe,
    input wire logic       hbr_n,
    input wire logic       cs_n,
    input wire logic       hbg_n,
    input wire logic       hbg_oe,
    input wire logic       host_access_ack,
    input wire logic       dma_request_a_n,
    input wire logic       dma_grant_a_n,
    input wire logic       dga_oe,
    input wire logic       dgb_oe,
    input wire logic       current_owner_flag,
    input wire logic [2:0] processor_id_pins
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [5:0] own_line; // One-hot own line, empty for ids 0 and 7
    assign own_line = (processor_id_pins inside {[3'h1:3'h6]}) ?
        6'h01 << (processor_id_pins - 3'h1) : 6'h00;
    // Host handover steps
    sequence s_float;
        !hbg_oe && !current_owner_flag;
    endsequence
    sequence s_grant;
        !hbg_n;
    endsequence
    property p_ack_cause;
        !host_access_ack |-> !$past(cs_n) && !$past(hbr_n);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack low without host access");
    property p_grant_a;
        $fell(dma_grant_a_n) |-> !$past(dma_request_a_n) ##1 dma_grant_a_n;
    endproperty
    a_grant_a: assert property (p_grant_a)
        else $error("grant a not a one cycle answer");
    property p_grant_owner;
        dga_oe || dgb_oe |-> current_owner_flag;
    endproperty
    a_grant_owner: assert property (p_grant_owner)
        else $error("grant driven by non owner");
    property p_own_line;
        (br_node_oe & ~own_line) == 6'h00;
    endproperty
    a_own_line: assert property (p_own_line)
        else $error("foreign request line driven");
    property p_flag_line;
        current_owner_flag && own_line != 6'h00 |-> (br_n & own_line) == 6'h00;
    endproperty
    a_flag_line: assert property (p_flag_line)
        else $error("owner flag without own request");
    property p_lone;
        processor_id_pins == MPBA_LONE_ID && hbr_n && $past(hbr_n)
            && $past(resetn, 2) |-> current_owner_flag;
    endproperty
    a_lone: assert property (p_lone)
        else $error("lone node flag low");
    property p_host;
        current_owner_flag && !hbr_n |=> s_float ##1 s_grant;
    endproperty
    a_host: assert property (p_host)
        else $error("host handover steps wrong");
    property p_host_hold;
        !hbg_n && !hbr_n |=> !hbg_n;
    endproperty
    a_host_hold: assert property (p_host_hold)
        else $error("host grant dropped early");
    property p_host_end;
        $rose(hbr_n) |-> ##[1:2] hbg_n;
    endproperty
    a_host_end: assert property (p_host_end)
        else $error("host grant kept after release");
endmodule
`default_nettype wire

/* test/multiprocessor_bus_arbitration_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Node facing the system model across one shared bus
module multiprocessor_bus_arbitration_tb_top;
    import mpba_pkg::*;
    logic       clock, resetn, bus_want, dma_allow, io_regs_ready;
    logic       bus_owned, bus_release, dma_start_a, dma_start_b;
    logic       host_owns_bus, host_want, host_select, rotate;
    logic       dma_want_a, dma_want_b, host_granted, host_wait;
    logic       dma_granted_a, dma_granted_b, node_master;
    logic [2:0] node_id;                // Id strapped on the node
    logic [5:0] peer_want, peer_present;
    int         miscompares, samples_checked;
    mpba_if i_mpba_if ();
    mpba_node i_mpba_node (.clock, .resetn, .pins(i_mpba_if), .bus_want,
        .dma_allow, .io_regs_ready, .bus_owned, .bus_release,
        .dma_start_a, .dma_start_b, .host_owns_bus);
    mpba_system i_mpba_system (.clock, .resetn, .pins(i_mpba_if), .node_id,
        .peer_want, .peer_present, .host_want, .host_select, .dma_want_a,
        .dma_want_b, .rotate, .host_granted, .host_wait, .dma_granted_a,
        .dma_granted_b, .node_master);
    mpba_checker i_mpba_checker (.clock, .resetn, .br_n(i_mpba_if.br_n),
        .br_node_oe(i_mpba_if.br_node_oe), .hbr_n(i_mpba_if.hbr_n),
        .cs_n(i_mpba_if.cs_n), .hbg_n(i_mpba_if.hbg_n),
        .hbg_oe(i_mpba_if.hbg_oe),
        .host_access_ack(i_mpba_if.host_access_ack),
        .dma_request_a_n(i_mpba_if.dma_request_a_n),
        .dma_grant_a_n(i_mpba_if.dma_grant_a_n),
        .dga_oe(i_mpba_if.dga_oe), .dgb_oe(i_mpba_if.dgb_oe),
        .current_owner_flag(i_mpba_if.current_owner_flag),
        .processor_id_pins(i_mpba_if.processor_id_pins));
    // ==========================================================
    // Helpers
    task automatic check(input string name, input logic [5:0] seen,
                         input logic [5:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Id only changes while reset is held
    task automatic do_reset(input logic [2:0] id);
        resetn  = 1'b0;
        node_id = id;
        cyc(16);
        resetn = 1'b1;
        cyc(2);
    endtask
    task automatic grab();
        bus_want = 1'b1;
        for (int k = 0; k < 20 && bus_owned !== 1'b1; k++) cyc(1);
        check("bus_owned", 6'(bus_owned), 6'h01);
    endtask
    // ==========================================================
    // Scenarios
    // Line 2 owns, line 1 and node (line 3) wait, line 2 lets go
    task automatic t_arb(input logic rot, input logic exp);
        rotate    = rot;
        peer_want = 6'h02;
        cyc(4);
        bus_want  = 1'b1;
        peer_want = 6'h03;
        cyc(4);
        check("own_req", 6'(i_mpba_if.br_n[2]), 6'h00);
        peer_want = 6'h01;
        cyc(8);
        check("node_master", 6'(node_master), 6'(exp));
        bus_want  = 1'b0;
        peer_want = 6'h00;
        cyc(4);
    endtask
    // Grant is one cycle, transfer starts the cycle after
    task automatic t_dma();
        logic [1:0] g;
        dma_allow = 1'b1;
        for (int i = 0; i < 2; i++) begin
            dma_want_a = (i == 0);
            dma_want_b = (i == 1);
            g = 2'h3;
            for (int k = 0; k < 10 && g == 2'h3; k++) begin
                cyc(1);
                g = {i_mpba_if.dma_grant_b_n, i_mpba_if.dma_grant_a_n};
            end
            check("grant", 6'(g), 6'(i == 0 ? 2'h2 : 2'h1));
            dma_want_a = 1'b0;
            dma_want_b = 1'b0;
            cyc(1);
            check("start", 6'({dma_start_b, dma_start_a}), 6'(i + 1));
            check("granted_seen", 6'({dma_granted_b, dma_granted_a}),
                  6'(i + 1));
            cyc(4);
        end
    endtask
    // Host takes the bus and waits on a slow register access
    task automatic t_host();
        host_select   = 1'b1;
        io_regs_ready = 1'b0;
        host_want     = 1'b1;
        for (int k = 0; k < 10 && host_owns_bus !== 1'b1; k++) cyc(1);
        cyc(1);
        check("host_grant", 6'(i_mpba_if.hbg_n), 6'h00);
        check("host_granted", 6'(host_granted), 6'h01);
        check("host_owns", 6'(host_owns_bus), 6'h01);
        check("release", 6'(bus_release), 6'h01);
        check("master_off", 6'(node_master), 6'h00);
        check("host_wait", 6'(host_wait), 6'h01);
        host_want     = 1'b0;
        host_select   = 1'b0;
        io_regs_ready = 1'b1;
        cyc(6);
        check("bus_back", 6'(bus_owned), 6'h01);
        check("grant_off", 6'(host_granted), 6'h00);
    endtask
    // Lone node drives no line and always shows ownership
    task automatic t_lone();
        do_reset(MPBA_LONE_ID);
        cyc(2);
        check("lone_flag", 6'(node_master), 6'h01);
        check("lone_oe", i_mpba_if.br_node_oe, 6'h00);
    endtask
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, stimulus and watchdog
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        {bus_want, dma_allow, host_want, host_select, rotate} = 5'h00;
        {dma_want_a, dma_want_b, io_regs_ready} = 3'h1;
        {miscompares, samples_checked} = 0;
        peer_want    = 6'h00;
        peer_present = 6'h3B; // Every line but the node's own
        do_reset(3'h3);
        t_arb(1'b0, 1'b0);
        t_arb(1'b1, 1'b1);
        grab();
        t_dma();
        t_host();
        bus_want = 1'b0;
        t_lone();
        conclude();
    end
    // Whole run is under 150 cycles
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
